// ===== verilog/ead_defines.svh
/*
 Offsets, field positions, reset values and pin codes of the external area
 decoder and its control register map.
 Assumes a word-addressed Avalon-MM slave port: each register offset is a word
 index, so the byte address is four times the index.
*/
`ifndef EAD_DEFINES_SVH
`define EAD_DEFINES_SVH

// Register word indices
`define EAD_IDX_BUS_CTRL_ONE 32'hFFFFFF60
`define EAD_IDX_BUS_CTRL_TWO 32'hFFFFFF62
`define EAD_IDX_WAIT_CTRL_ONE 32'h0FFFFF64
`define EAD_IDX_WAIT_CTRL_TWO 32'hFFFFFF66
`define EAD_IDX_PER_MEM_CTRL 32'h0FFFFF68
`define EAD_IDX_DYN_MEM_CTRL 32'h0FFFFF6A
`define EAD_IDX_CARD_IF_CTRL 32'hFFFFFF6C
`define EAD_IDX_REFR_CSR 32'h0FFFFF6E
`define EAD_IDX_REFR_COUNT 32'hFFFFFF70
`define EAD_IDX_REFR_CONST 32'hFFFFFF72
`define EAD_IDX_REFR_TALLY 32'hFFFFFF74
// Read-only block status word
`define EAD_IDX_STATUS 32'hFFFFFF7E
// Write-only synchronous memory mode windows (inclusive ranges)
`define EAD_IDX_SYNC_TWO_LO 32'hFFFFD000
`define EAD_IDX_SYNC_TWO_HI 32'hFFFFDFFF
`define EAD_IDX_SYNC_THREE_LO 32'hFFFFE000
`define EAD_IDX_SYNC_THREE_HI 32'hFFFFEFFF

// Power-on values
`define EAD_RST_BUS_CTRL_ONE 16'h0000
`define EAD_RST_BUS_CTRL_TWO 16'h3FFC
`define EAD_RST_WAIT_CTRL_ONE 16'h3FFF
`define EAD_RST_WAIT_CTRL_TWO 16'hFFFF
`define EAD_RST_ZERO 16'h0000

// Bus control one fields
`define EAD_BC1_AREA6_CARD 0
`define EAD_BC1_AREA5_CARD 1
`define EAD_BC1_DYNTYPE_LSB 2
`define EAD_BC1_DYNTYPE_MSB 4
// Dynamic type codes: area 3 dynamic from LOW through BOTH, area 2 as well at BOTH
`define EAD_DYNTYPE_AREA3_LOW 3'h2
`define EAD_DYNTYPE_BOTH 3'h5

// Area 0 width strap codes {high pin, low pin}
`define EAD_WIDTH_RESERVED 2'h0
`define EAD_WIDTH_8 2'h1
`define EAD_WIDTH_16 2'h2
`define EAD_WIDTH_32 2'h3

`endif

// ===== verilog/ead_pkg.sv
/*
 Types shared by the external area decoder files.
 Assumes ead_defines.svh carries every number.
*/
`default_nettype none
package ead_pkg;

   // Area code taken from address bits 28..26
   typedef enum logic [2:0]
   {
      EAD_AREA_0 = 3'b000,
      EAD_AREA_1 = 3'b001,
      EAD_AREA_2 = 3'b010,
      EAD_AREA_3 = 3'b011,
      EAD_AREA_4 = 3'b100,
      EAD_AREA_5 = 3'b101,
      EAD_AREA_6 = 3'b110,
      EAD_AREA_RSVD = 3'b111
   } ead_area_t;

   // Seven external area selects, bit k for area k
   typedef logic [6:0] ead_selects_t;

endpackage : ead_pkg

`default_nettype wire

// ===== verilog/ead_area_decode.sv
/*
 Combinational area decode: next values of the area selects, the dynamic
 memory strobes and the card-enable strobes for the access now presented.
 Assumes the caller registers every output and supplies configuration bits.
*/
`timescale 1ns/1ps
`default_nettype none

module ead_area_decode
#(
   parameter int NUM_AREAS = 7
)
(
   // Access presented by the processor
   input wire logic req,
   input wire ead_pkg::ead_area_t area,
   input wire logic write,
   input wire logic [3:0] byte_en,
   // Configuration
   input wire logic dyn_area2,
   input wire logic dyn_area3,
   input wire logic card_area5,
   input wire logic card_area6,
   // Next output values
   output ead_pkg::ead_selects_t sel_n_next,
   output logic ras_n_next,
   output logic cas_n_next,
   output logic rd_wr_next,
   output logic [3:0] dqm_n_next,
   output logic ce2_first_n_next,
   output logic ce2_second_n_next
);
   import ead_pkg::*;

   // Elaboration refuses any other area count
   if (NUM_AREAS != 7)
   begin : g_bad_areas
      $error("ead_area_decode serves exactly seven external areas");
   end

   logic dyn_hit; // Access lands in a dynamic-memory area
   logic odd_lane; // Upper byte of a halfword is being accessed

   // One select per area; the reserved code matches none of them
   genvar k;
   generate
      for (k = 0; k < NUM_AREAS; k++)
      begin : g_sel
         assign sel_n_next[k] = ~(req && (area == ead_area_t'(k))); // R2 R3 R13
      end
   endgenerate

   assign dyn_hit = req && (((area == EAD_AREA_2) && dyn_area2) ||
                            ((area == EAD_AREA_3) && dyn_area3));
   // Second card enable covers the odd byte lanes
   assign odd_lane = byte_en[1] | byte_en[3];

   // Memory strobes stay idle outside dynamic areas
   always_comb
   begin
      ras_n_next = ~dyn_hit; // R4
      cas_n_next = ~dyn_hit; // R4
      rd_wr_next = ~(dyn_hit && write); // R4
      dqm_n_next = dyn_hit ? ~byte_en : 4'hF; // R4
      ce2_first_n_next = ~(req && card_area5 && (area == EAD_AREA_5) && odd_lane); // R5
      ce2_second_n_next = ~(req && card_area6 && (area == EAD_AREA_6) && odd_lane); // R5
   end

endmodule : ead_area_decode

`default_nettype wire

// ===== verilog/ead_area_regmap.sv
/*
 Top of the external area decoder: registered area selects and memory
 strobes, the eleven control registers, the write-only synchronous memory
 mode settings and the area 0 width strap, behind an Avalon-MM slave.
 Assumes RST_N is the power-on reset, synchronous to REF_CLK, and that the
 access request comes from logic on REF_CLK.
*/
// Notes on behaviour
// (R1) Physical space 29 bits, eight areas
// (R2) One active-low select per external area
// (R3) Area k access asserts select k only
// (R4) Dynamic areas 2/3 also drive memory strobes
// (R5) Card areas 5/6 drive second card enable
// (R6) Shadow copies decode same as base range
// (R7) Accessor must avoid reserved area 7
// (R8) Eleven 16-bit readable writable control registers
// (R9) Initial values loaded only at power-on
// (R10) Mode setting write-only, 8 bits, two windows
// (R11) Area from bits 28..26, ignore 31..29
// (R12) Area 0 width from two mode pins
// (R13) No select active outside bus cycles
`timescale 1ns/1ps
`default_nettype none
`include "ead_defines.svh"

module ead_area_regmap
#(
   parameter int NUM_REGS = 11
)
(
   // Clock and power-on reset
   input wire logic REF_CLK,
   input wire logic RST_N,
   // Processor physical access
   input wire logic ACCESS_REQ,
   input wire logic [31:0] ACCESS_ADDR,
   input wire logic ACCESS_WRITE,
   input wire logic [3:0] ACCESS_BYTE_EN,
   // Avalon-MM register slave, word addressed
   input wire logic [31:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   // Area selects and dynamic memory strobes
   output ead_pkg::ead_selects_t AREA_SELECTS_N,
   output logic ROW_STROBE_N,
   output logic COL_STROBE_N,
   output logic RD_WR,
   output logic [3:0] DATA_MASK_N,
   // Shared mode-pin / card-enable pins
   input wire logic WIDTH_MODE_PIN_LOW_IN,
   output logic CARD_ENABLE2_FIRST_N,
   output logic CARD_ENABLE2_FIRST_OE,
   input wire logic WIDTH_MODE_PIN_HIGH_IN,
   output logic CARD_ENABLE2_SECOND_N,
   output logic CARD_ENABLE2_SECOND_OE,
   // Captured settings
   output logic [1:0] AREA0_WIDTH,
   output logic [7:0] SYNC_MODE_AREA_TWO,
   output logic [7:0] SYNC_MODE_AREA_THREE
);
   import ead_pkg::*;

   if (NUM_REGS != 11)
   begin : g_bad_regs
      $error("ead_area_regmap holds exactly eleven control registers");
   end

   // Register slots, in decode order
   localparam logic [3:0] SLOT_BUS1 = 4'h0;
   localparam logic [3:0] SLOT_SYNC2 = 4'hB;
   localparam logic [3:0] SLOT_SYNC3 = 4'hC;
   localparam logic [3:0] SLOT_STATUS = 4'hD;
   localparam logic [3:0] SLOT_NONE = 4'hF;
   localparam logic [15:0] RESET_VALS [0:10] = '{
      `EAD_RST_BUS_CTRL_ONE, `EAD_RST_BUS_CTRL_TWO, `EAD_RST_WAIT_CTRL_ONE,
      `EAD_RST_WAIT_CTRL_TWO, `EAD_RST_ZERO, `EAD_RST_ZERO, `EAD_RST_ZERO,
      `EAD_RST_ZERO, `EAD_RST_ZERO, `EAD_RST_ZERO, `EAD_RST_ZERO};

   logic [15:0] ctrl_reg [0:10]; // Control registers
   logic [7:0] sync_two_reg; // Mode setting, area 2 window
   logic [7:0] sync_three_reg; // Mode setting, area 3 window
   logic ack_reg; // Bus answer phase
   logic [31:0] rdata_reg; // Read data, valid in the answer phase
   logic [3:0] slot; // Decoded register slot
   logic bus_req; // Read or write pending
   logic wr_take; // Write takes effect at this edge
   logic [1:0] pin_meta_reg; // First synchroniser stage for both mode pins
   logic [1:0] pin_sync_reg; // Second stage
   logic strap_done_reg; // Width captured since reset release
   logic [1:0] width_reg; // Area 0 width code
   ead_area_t area; // Area of the access presented
   ead_area_t last_area_reg; // Area of the last access
   logic dyn2, dyn3, card5, card6; // Configuration decoded from bus control one
   logic [2:0] dyn_type; // Dynamic memory type field
   ead_selects_t sel_n_next;
   logic ras_n_next, cas_n_next, rd_wr_next, card_enable2_first_n_n_next, card_enable2_second_n_n_next;
   logic [3:0] dqm_n_next;

   // Word-index decode; unmapped indices fall to SLOT_NONE
   function automatic logic [3:0] slot_of(input logic [31:0] idx);
      logic [3:0] s;
      s = SLOT_NONE;
      case (idx)
         `EAD_IDX_BUS_CTRL_ONE: s = 4'h0;
         `EAD_IDX_BUS_CTRL_TWO: s = 4'h1;
         `EAD_IDX_WAIT_CTRL_ONE: s = 4'h2;
         `EAD_IDX_WAIT_CTRL_TWO: s = 4'h3;
         `EAD_IDX_PER_MEM_CTRL: s = 4'h4;
         `EAD_IDX_DYN_MEM_CTRL: s = 4'h5;
         `EAD_IDX_CARD_IF_CTRL: s = 4'h6;
         `EAD_IDX_REFR_CSR: s = 4'h7;
         `EAD_IDX_REFR_COUNT: s = 4'h8;
         `EAD_IDX_REFR_CONST: s = 4'h9;
         `EAD_IDX_REFR_TALLY: s = 4'hA;
         `EAD_IDX_STATUS: s = SLOT_STATUS;
         default:
         begin
            if (idx >= `EAD_IDX_SYNC_TWO_LO && idx <= `EAD_IDX_SYNC_TWO_HI)
               s = SLOT_SYNC2; // R10
            else if (idx >= `EAD_IDX_SYNC_THREE_LO && idx <= `EAD_IDX_SYNC_THREE_HI)
               s = SLOT_SYNC3; // R10
         end
      endcase
      return s;
   endfunction : slot_of

   assign slot = slot_of(AVS_ADDRESS);
   assign bus_req = AVS_READ | AVS_WRITE;
   // One wait cycle, so decode never sits on the read-data path
   assign AVS_WAITREQUEST = bus_req & ~ack_reg;
   assign wr_take = AVS_WRITE & ack_reg;
   assign AVS_READDATA = rdata_reg;

   // Answer phase toggles in for one cycle per request
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
         ack_reg <= 1'b0;
      else
         ack_reg <= bus_req & ~ack_reg;
   end

   // Read data latched in the wait cycle; write-only and unmapped read zero
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
         rdata_reg <= 32'h0000_0000;
      else if (AVS_READ && !ack_reg)
      begin
         if (slot < SLOT_SYNC2)
            rdata_reg <= {16'h0000, ctrl_reg[slot]}; // R8
         else if (slot == SLOT_STATUS)
            rdata_reg <= {26'h000_0000, strap_done_reg, last_area_reg, width_reg};
         else
            rdata_reg <= 32'h0000_0000; // R10
      end
   end

   // Control registers; power-on reset is the only path to initial values
   genvar i;
   generate
      for (i = 0; i < NUM_REGS; i++)
      begin : g_ctrl
         always_ff @(posedge REF_CLK)
         begin
            if (!RST_N)
               ctrl_reg[i] <= RESET_VALS[i]; // R9
            else if (wr_take && slot == 4'(i))
            begin
               if (AVS_BYTEENABLE[0])
                  ctrl_reg[i][7:0] <= AVS_WRITEDATA[7:0]; // R8
               if (AVS_BYTEENABLE[1])
                  ctrl_reg[i][15:8] <= AVS_WRITEDATA[15:8]; // R8
            end
         end
      end
   endgenerate

   // Write-only mode settings; no documented initial value, cleared anyway
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         sync_two_reg <= 8'h00;
         sync_three_reg <= 8'h00;
      end
      else if (wr_take && AVS_BYTEENABLE[0])
      begin
         if (slot == SLOT_SYNC2)
            sync_two_reg <= AVS_WRITEDATA[7:0]; // R10
         if (slot == SLOT_SYNC3)
            sync_three_reg <= AVS_WRITEDATA[7:0]; // R10
      end
   end
   assign SYNC_MODE_AREA_TWO = sync_two_reg;
   assign SYNC_MODE_AREA_THREE = sync_three_reg;

   // Mode pins are asynchronous: two flops before anything reads them
   always_ff @(posedge REF_CLK)
   begin
      pin_meta_reg <= {WIDTH_MODE_PIN_HIGH_IN, WIDTH_MODE_PIN_LOW_IN};
      pin_sync_reg <= pin_meta_reg;
   end

   // Strap caught once, in the first cycle after reset release
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         strap_done_reg <= 1'b0;
         width_reg <= `EAD_WIDTH_RESERVED;
      end
      else if (!strap_done_reg)
      begin
         strap_done_reg <= 1'b1;
         width_reg <= pin_sync_reg; // R12
      end
   end
   assign AREA0_WIDTH = width_reg;

   // Configuration from bus control one
   assign dyn_type = ctrl_reg[SLOT_BUS1][`EAD_BC1_DYNTYPE_MSB:`EAD_BC1_DYNTYPE_LSB];
   assign dyn3 = (dyn_type >= `EAD_DYNTYPE_AREA3_LOW) && (dyn_type <= `EAD_DYNTYPE_BOTH);
   assign dyn2 = (dyn_type == `EAD_DYNTYPE_BOTH);
   assign card5 = ctrl_reg[SLOT_BUS1][`EAD_BC1_AREA5_CARD];
   assign card6 = ctrl_reg[SLOT_BUS1][`EAD_BC1_AREA6_CARD];
   // Shared pins turn to outputs only in card mode, so the strap is read first
   assign CARD_ENABLE2_FIRST_OE = card5; // R5
   assign CARD_ENABLE2_SECOND_OE = card6; // R5

   // Bits 31..29 never reach the decode, so shadows alias the base range
   assign area = ead_area_t'(ACCESS_ADDR[28:26]); // R1 R6 R11

   ead_area_decode #(.NUM_AREAS(7)) u_decode
   (
      .req(ACCESS_REQ),
      .area(area),
      .write(ACCESS_WRITE),
      .byte_en(ACCESS_BYTE_EN),
      .dyn_area2(dyn2),
      .dyn_area3(dyn3),
      .card_area5(card5),
      .card_area6(card6),
      .sel_n_next(sel_n_next),
      .ras_n_next(ras_n_next),
      .cas_n_next(cas_n_next),
      .rd_wr_next(rd_wr_next),
      .dqm_n_next(dqm_n_next),
      .ce2_first_n_next(card_enable2_first_n_n_next),
      .ce2_second_n_next(card_enable2_second_n_n_next)
   );

   // Pin outputs registered one cycle after the request; idle when reset
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         AREA_SELECTS_N <= 7'h7F; // R13
         ROW_STROBE_N <= 1'b1;
         COL_STROBE_N <= 1'b1;
         RD_WR <= 1'b1;
         DATA_MASK_N <= 4'hF;
         CARD_ENABLE2_FIRST_N <= 1'b1;
         CARD_ENABLE2_SECOND_N <= 1'b1;
      end
      else
      begin
         AREA_SELECTS_N <= sel_n_next; // R2 R13
         ROW_STROBE_N <= ras_n_next; // R4
         COL_STROBE_N <= cas_n_next;
         RD_WR <= rd_wr_next;
         DATA_MASK_N <= dqm_n_next;
         CARD_ENABLE2_FIRST_N <= card_enable2_first_n_n_next; // R5
         CARD_ENABLE2_SECOND_N <= card_enable2_second_n_n_next;
      end
   end

   // Last area seen, reported in the status word
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
         last_area_reg <= EAD_AREA_0;
      else if (ACCESS_REQ)
         last_area_reg <= area;
   end

   // Checks on the pins and the register slave
   sequence s_access(logic [2:0] code);
      ACCESS_REQ && (ACCESS_ADDR[28:26] == code);
   endsequence

   sequence s_bus_answer;
      AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
   endsequence

   a_select_follows_addr: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R6
      ACCESS_REQ && ACCESS_ADDR[28:26] != 3'h7 |=>
      AREA_SELECTS_N == ~(7'h01 << $past(ACCESS_ADDR[28:26])))
      else $error("select does not match address bits 28..26");
   a_area_zero_select: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R3
      s_access(3'h0) |=> !AREA_SELECTS_N[0] && AREA_SELECTS_N[6:1] == 6'h3F)
      else $error("area 0 access without sole area 0 select");
   a_area_six_select: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R3
      s_access(3'h6) |=> !AREA_SELECTS_N[6] && AREA_SELECTS_N[5:0] == 6'h3F)
      else $error("area 6 access without sole area 6 select");
   a_select_onehot: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R2
      $onehot0(~AREA_SELECTS_N))
      else $error("more than one area select active");
   a_idle_no_select: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R13
      !ACCESS_REQ |=> AREA_SELECTS_N == 7'h7F)
      else $error("select active outside a bus cycle");
   a_dyn_strobes: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R4
      s_access(3'h3) ##0 dyn3 |=> !ROW_STROBE_N && !COL_STROBE_N &&
      DATA_MASK_N == ~$past(ACCESS_BYTE_EN) && RD_WR == !$past(ACCESS_WRITE))
      else $error("area 3 dynamic access without memory strobes");
   a_card_enable: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R5
      s_access(3'h5) ##0 (card5 && ACCESS_BYTE_EN[1]) |=>
      !CARD_ENABLE2_FIRST_N && !AREA_SELECTS_N[5])
      else $error("area 5 card access without second card enable");
   a_bus_answer: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R8
      $rose(bus_req) |-> s_bus_answer)
      else $error("register slave did not answer after one wait cycle");
   a_wo_reads_zero: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R10
      AVS_READ && !ack_reg && (slot == SLOT_SYNC2 || slot == SLOT_SYNC3) |=>
      AVS_READDATA == 32'h0000_0000)
      else $error("write-only mode setting read back nonzero");
   a_power_on_values: assert property (@(posedge REF_CLK) // R9
      !RST_N |=> ctrl_reg[1] == `EAD_RST_BUS_CTRL_TWO &&
      ctrl_reg[3] == `EAD_RST_WAIT_CTRL_TWO && ctrl_reg[2] == `EAD_RST_WAIT_CTRL_ONE)
      else $error("control register not at power-on value after reset");
   a_strap_capture: assert property (@(posedge REF_CLK) disable iff (!RST_N) // R12
      !strap_done_reg |=> strap_done_reg && width_reg == $past(pin_sync_reg))
      else $error("area 0 width not taken from mode pins");

endmodule : ead_area_regmap

`default_nettype wire

// ===== sim/ead_far_side.sv
/*
 Far-side board model for the external area decoder: strap resistors on the
 two shared width-mode / card-enable pins.
 Assumes the block drives a pin only while its output enable is high.
*/
`timescale 1ns/1ps
`default_nettype none

module ead_far_side
(
   // Strap levels fitted on the board, {high pin, low pin}
   input wire logic [1:0] strap,
   // Card-enable pins as driven by the block
   input wire logic ce2_first_n,
   input wire logic ce2_first_oe,
   input wire logic ce2_second_n,
   input wire logic ce2_second_oe,
   // Levels seen on the shared pins
   output logic pin_low,
   output logic pin_high
);
   // Block wins while enabled; otherwise the strap resistor sets the level
   assign pin_low = ce2_first_oe ? ce2_first_n : strap[0];
   // Same sharing on the second pin, used by area 6 cards
   assign pin_high = ce2_second_oe ? ce2_second_n : strap[1];
endmodule : ead_far_side

`default_nettype wire

// ===== sim/tb.sv
/*
 Self-checking bench for the external area decoder: Avalon-MM register
 tasks, physical access tasks and sequences of calls with expected values.
 Assumes a word-addressed slave with one wait cycle and registered pins.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ead_defines.svh"
`define CHK(nm, ex, gt) \
   comparisons++; \
   if ((gt) !== (ex)) \
   begin \
      $display("wrong value %s expected %0h seen %0h", nm, ex, gt); \
      err_total++; \
   end

module tb;
   import ead_pkg::*;
   // Clock, reset and physical access
   logic ref_clk, rst_n, acc_req, acc_write;
   logic [31:0] acc_addr;
   logic [3:0] acc_be;
   // Register bus
   logic [31:0] av_addr, av_wdata, av_rdata, rd;
   logic av_read, av_write, av_wait;
   // Pins and settings seen from outside
   ead_selects_t sel_n;
   logic row_n, col_n, rd_wr, pin_low, pin_high, ce1_n, ce1_oe, ce2_n, ce2_oe;
   logic [3:0] dqm_n;
   logic [1:0] strap, width;
   logic [7:0] mode2, mode3;
   // Settled copies of bus answers, taken mid-cycle to avoid edge races
   logic wait_mid;
   logic [31:0] rdata_mid;
   logic [6:0] exp_sel;
   int err_total, comparisons, i, n, a;
   // Register indices and power-on values, in slot order
   logic [31:0] reg_idx [11] = '{`EAD_IDX_BUS_CTRL_ONE, `EAD_IDX_BUS_CTRL_TWO,
      `EAD_IDX_WAIT_CTRL_ONE, `EAD_IDX_WAIT_CTRL_TWO, `EAD_IDX_PER_MEM_CTRL,
      `EAD_IDX_DYN_MEM_CTRL, `EAD_IDX_CARD_IF_CTRL, `EAD_IDX_REFR_CSR,
      `EAD_IDX_REFR_COUNT, `EAD_IDX_REFR_CONST, `EAD_IDX_REFR_TALLY};
   logic [15:0] reg_rst [11] = '{16'h0000, 16'h3FFC, 16'h3FFF, 16'hFFFF, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

   // Block under test
   ead_area_regmap i_ead_area_regmap (.REF_CLK(ref_clk), .RST_N(rst_n),
      .ACCESS_REQ(acc_req), .ACCESS_ADDR(acc_addr), .ACCESS_WRITE(acc_write),
      .ACCESS_BYTE_EN(acc_be), .AVS_ADDRESS(av_addr), .AVS_READ(av_read),
      .AVS_WRITE(av_write), .AVS_WRITEDATA(av_wdata), .AVS_BYTEENABLE(4'hF),
      .AVS_READDATA(av_rdata), .AVS_WAITREQUEST(av_wait), .AREA_SELECTS_N(sel_n),
      .ROW_STROBE_N(row_n), .COL_STROBE_N(col_n), .RD_WR(rd_wr), .DATA_MASK_N(dqm_n),
      .WIDTH_MODE_PIN_LOW_IN(pin_low), .CARD_ENABLE2_FIRST_N(ce1_n),
      .CARD_ENABLE2_FIRST_OE(ce1_oe), .WIDTH_MODE_PIN_HIGH_IN(pin_high),
      .CARD_ENABLE2_SECOND_N(ce2_n), .CARD_ENABLE2_SECOND_OE(ce2_oe),
      .AREA0_WIDTH(width), .SYNC_MODE_AREA_TWO(mode2), .SYNC_MODE_AREA_THREE(mode3));

   // Board straps and pin sharing
   ead_far_side i_ead_far_side (.strap(strap), .ce2_first_n(ce1_n),
      .ce2_first_oe(ce1_oe), .ce2_second_n(ce2_n), .ce2_second_oe(ce2_oe),
      .pin_low(pin_low), .pin_high(pin_high));

   // 25 MHz clock
   always #20 ref_clk = ~ref_clk;

   // Mid-cycle copies equal the values present at the next rising edge
   always @(negedge ref_clk)
   begin
      wait_mid = av_wait;
      rdata_mid = av_rdata;
   end

   // Counts, verdict and end of run
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : test_done

   // One Avalon transfer, held until waitrequest is seen low at an edge
   task automatic av_xfer(input logic wr, input logic [31:0] adr, input logic [31:0] d,
                          output logic [31:0] q);
      int k;
      k = 0;
      @(posedge ref_clk);
      av_addr <= adr;
      av_wdata <= d;
      av_write <= wr;
      av_read <= ~wr;
      @(posedge ref_clk);
      // Bounded wait: a slave that never answers ends the run
      while (wait_mid !== 1'b0 && k < 20)
      begin
         @(posedge ref_clk);
         k++;
      end
      if (wait_mid !== 1'b0)
      begin
         err_total++;
         test_done();
      end
      else
      begin
         // Answer seen low at this edge: take read data, then release
         q = rdata_mid;
         av_write <= 1'b0;
         av_read <= 1'b0;
      end
   endtask : av_xfer

   // Read one register and compare
   task automatic chk_reg(input logic [31:0] adr, input logic [31:0] ex, input string nm);
      logic [31:0] q;
      av_xfer(1'b0, adr, 32'h0000_0000, q);
      `CHK(nm, ex, q)
   endtask : chk_reg

   // Physical access held for one sampling edge; pins checked mid-cycle after it
   task automatic access(input logic [2:0] ar, input logic [2:0] sh, input logic wr,
                         input logic [3:0] be);
      @(posedge ref_clk);
      acc_req <= 1'b1;
      acc_addr <= {sh, ar, 26'h2AA_AAAA};
      acc_write <= wr;
      acc_be <= be;
      @(posedge ref_clk);
      @(negedge ref_clk);
   endtask : access

   // No bus cycle in progress
   task automatic idle;
      @(posedge ref_clk);
      acc_req <= 1'b0;
      @(posedge ref_clk);
      @(negedge ref_clk);
   endtask : idle

   // Watchdog against a hang anywhere in the sequence
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      err_total++;
      test_done();
   end

   // Main sequence
   initial
   begin
      ref_clk = 1'b0;
      rst_n = 1'b0;
      {acc_req, acc_write, av_read, av_write} = 4'h0;
      acc_addr = 32'h0000_0000;
      acc_be = 4'h0;
      av_addr = 32'h0000_0000;
      av_wdata = 32'h0000_0000;
      strap = 2'b10;
      err_total = 0;
      comparisons = 0;
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      `CHK("area0 width", `EAD_WIDTH_16, width)
      `CHK("idle selects", 7'h7F, sel_n)
      for (i = 0; i < 11; i++)
         chk_reg(reg_idx[i], {16'h0000, reg_rst[i]}, "power-on value");
      // Status: strap done, no access yet, width code 16 bits
      chk_reg(`EAD_IDX_STATUS, 32'h0000_0022, "status word");
      $display("test power-on values done");
      // Write all first, then read all, so aliased registers show up
      for (i = 0; i < 11; i++)
         av_xfer(1'b1, reg_idx[i], {16'hFFFF, 16'hC3A0 + 16'(i)}, rd);
      for (i = 0; i < 11; i++)
         chk_reg(reg_idx[i], {16'h0000, 16'hC3A0 + 16'(i)}, "readback");
      av_xfer(1'b1, 32'hFFFF_FF50, 32'h0000_1234, rd);
      chk_reg(32'hFFFF_FF50, 32'h0000_0000, "unmapped");
      av_xfer(1'b1, `EAD_IDX_SYNC_TWO_LO, 32'h0000_00A5, rd);
      av_xfer(1'b1, `EAD_IDX_SYNC_THREE_HI, 32'h0000_003C, rd);
      @(negedge ref_clk);
      `CHK("mode area two", 8'hA5, mode2)
      `CHK("mode area three", 8'h3C, mode3)
      chk_reg(`EAD_IDX_SYNC_TWO_LO, 32'h0000_0000, "mode write-only");
      $display("test registers done");
      // Plain memory everywhere; every area in every shadow, back to back
      av_xfer(1'b1, `EAD_IDX_BUS_CTRL_ONE, 32'h0000_0000, rd);
      for (n = 0; n < 8; n++)
         // Reserved area 7 and its shadows are never accessed
         for (a = 0; a < 7; a++)
         begin
            access(3'(a), 3'(n), 1'b0, 4'hF);
            exp_sel = ~(7'h01 << a);
            `CHK("area selects", exp_sel, sel_n)
            `CHK("row strobe plain", 1'b1, row_n)
         end
      idle();
      `CHK("selects after cycle", 7'h7F, sel_n)
      $display("test area decode done");
      // Areas 2 and 3 dynamic
      av_xfer(1'b1, `EAD_IDX_BUS_CTRL_ONE, 32'h0000_0014, rd);
      access(3'd3, 3'd0, 1'b1, 4'h3);
      `CHK("dyn selects", 7'h77, sel_n)
      `CHK("dyn strobes", 6'h00, {row_n, col_n, rd_wr, 3'h0})
      `CHK("dyn mask", 4'hC, dqm_n)
      access(3'd2, 3'd1, 1'b0, 4'hF);
      `CHK("dyn read", 3'h1, {row_n, col_n, rd_wr})
      `CHK("dyn read mask", 4'h0, dqm_n)
      access(3'd1, 3'd0, 1'b1, 4'h3);
      `CHK("plain strobes", 7'h7F, {row_n, col_n, rd_wr, dqm_n})
      // Only area 3 dynamic now
      av_xfer(1'b1, `EAD_IDX_BUS_CTRL_ONE, 32'h0000_0008, rd);
      access(3'd2, 3'd0, 1'b1, 4'hF);
      `CHK("area2 not dyn", 1'b1, row_n)
      access(3'd3, 3'd0, 1'b1, 4'hF);
      `CHK("area3 dyn", 1'b0, row_n)
      idle();
      $display("test dynamic strobes done");
      // Card mode in areas 5 and 6
      av_xfer(1'b1, `EAD_IDX_BUS_CTRL_ONE, 32'h0000_0003, rd);
      // Area 5 pairs with the first card enable, area 6 with the second
      access(3'd5, 3'd0, 1'b0, 4'h2);
      `CHK("area5 card", 10'h2FB, {sel_n, ce1_n, ce2_n, ce1_oe})
      access(3'd6, 3'd2, 1'b1, 4'h8);
      `CHK("area6 card", 10'h1FD, {sel_n, ce1_n, ce2_n, ce2_oe})
      access(3'd6, 3'd0, 1'b0, 4'h1);
      `CHK("even lane", 1'b1, ce2_n)
      idle();
      `CHK("card idle", 2'h3, {ce1_n, ce2_n})
      $display("test card strobes done");
      // Second power-on reset with another strap
      @(posedge ref_clk);
      strap <= 2'b01;
      rst_n <= 1'b0;
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      `CHK("area0 width again", `EAD_WIDTH_8, width)
      `CHK("mode after reset", 8'h00, mode2)
      chk_reg(`EAD_IDX_BUS_CTRL_ONE, 32'h0000_0000, "bus control reload");
      chk_reg(`EAD_IDX_WAIT_CTRL_TWO, 32'h0000_FFFF, "wait control reload");
      $display("test second reset done");
      test_done();
   end
endmodule : tb

`default_nettype wire
